// [shared/fault_sup_pkg.sv]
// Package for the high-side fault supervisor: constants, status layout, carriers.
// Assumes all comparator inputs are already digital levels from the analog front end.
package fault_sup_pkg;

    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned WORD_BITS     = 8;
    localparam int unsigned LOW_SEL_BITS  = 3;
    localparam int unsigned FILT_SEL_BITS = 2;

    // Overcurrent filter times in microseconds, selected by a 2-bit code
    localparam int unsigned OC_FILT_US0 = 1;
    localparam int unsigned OC_FILT_US1 = 2;
    localparam int unsigned OC_FILT_US2 = 4;
    localparam int unsigned OC_FILT_US3 = 8;
    localparam int unsigned CYC_PER_US  = CLK_HZ / 1_000_000;
    localparam int unsigned FILT_CNT_W  = 10;

    // Status word bit positions
    localparam int unsigned ST_THERMAL = 0;
    localparam int unsigned ST_HIGHBAT = 1;
    localparam int unsigned ST_LOWBAT  = 2;
    localparam int unsigned ST_OPEN    = 3;
    localparam int unsigned ST_OC_LOW  = 4;
    localparam int unsigned ST_OC_HIGH = 5;
    localparam int unsigned ST_GND     = 6;
    localparam int unsigned ST_OUTON   = 7;

    localparam logic [WORD_BITS-1:0] STATUS_RST = 8'h00;

    // Protection configuration held by the serial registers
    typedef struct packed {
        logic                     high_battery_guard_off;
        logic                     low_battery_guard_off;
        logic                     open_detect_off;
        logic [LOW_SEL_BITS-1:0]  low_overcurrent_level;
        logic                     high_overcurrent_level;
        logic [FILT_SEL_BITS-1:0] overcurrent_filter_time;
    } prot_cfg_t;

    localparam prot_cfg_t CFG_DEFAULT = '0;

    // Comparator levels from the analog front end
    typedef struct packed {
        logic                    over_temp;
        logic                    over_volt;
        logic                    below_uv;
        logic                    below_por;
        logic                    above_min;
        logic                    open_load;
        logic                    gate_low;
        logic [(1<<LOW_SEL_BITS)-1:0] oc_low_hit;
        logic [1:0]              oc_high_hit;
        logic                    gnd_lost;
    } sense_t;

    typedef enum logic [1:0] { OUT_IDLE, OUT_ON, OUT_LATCHED } out_state_t;

endpackage : fault_sup_pkg

// [rtl/sync2.sv]
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes the levels are quasi-static compared with the clock.
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            dout   <= '0;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : sync2
`default_nettype wire

// [rtl/oc_filter.sv]
// Overcurrent low filter: counts cycles the selected low level is exceeded.
// Assumes the level input is synchronised and the limit is at least one.
`timescale 1ns/10ps
`default_nettype none
module oc_filter
    import fault_sup_pkg::*;
#(
    parameter int unsigned CW = FILT_CNT_W
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          active,
    input  wire logic [CW-1:0] limit,
    output logic               expired
);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cnt_q   <= '0;
            expired <= 1'b0;
        end
        else if (!active)
        begin
            cnt_q   <= '0;
            expired <= 1'b0;
        end
        else if (cnt_q >= limit)
        begin
            expired <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule : oc_filter
`default_nettype wire

// [rtl/high_side_fault_supervisor.sv]
// High-side switch fault supervisor: protections, fault pad, latched status.
// Assumes a serial front end delivers config, a read strobe and a frame start.
// Operation
// - Logic supply loss resets configuration; direct input still drives output.
// - Without logic supply protections run on default settings and default sense ratio.
// - Fault pad low on thermal, battery high/low, open-load or overcurrent.
// - Fault pad releases when fault ends, except overcurrent and some undervoltage.
// - Fault bits held, shifted out on first valid transfer, and cleared.
// - Thermal detection only while the output is on.
// - Thermal fault turns output off until cooled, then resumes, repeating.
// - Thermal flag set, cleared only by valid read or reset.
// - Battery high holds output off; flag in status bit one until read.
// - A control bit disables battery-high shutdown and its reporting.
// - Battery low: output off, fault pad low, low-battery flag set.
// - Recovery with command off releases pad; flag stays until read.
// - Recovery with command on keeps output off, pad low, until off-on cycle.
// - Low-battery guard off: no report, output unchanged above 2.5 V.
// - Open load detected only while off, after gate low; cleared on read.
// - Eight low overcurrent levels, two high levels, one of each active.
// - Low overcurrent beyond filter time latches output off.
// - High overcurrent latches and switches off at once.
// - Overcurrent latch holds output off until commanded off then on.
// - Between reset threshold and 2.5 V: output off, pad high, flag held.
// - Ground disconnect switches output off regardless of state.
`timescale 1ns/10ps
`default_nettype none
module high_side_fault_supervisor
    import fault_sup_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 logic_supply_ok,
    input  wire logic                 direct_in,
    input  wire logic                 serial_on_cmd,
    input  wire prot_cfg_t            cfg_in,
    input  wire logic                 cfg_load,
    input  wire logic                 frame_start,
    input  wire logic                 read_valid,
    input  wire sense_t               sense,
    output logic                      output_gate,
    output logic                      fault_indicator_pad_n,
    output logic                      sense_ratio_default,
    output logic [WORD_BITS-1:0]      status_word,
    output logic [WORD_BITS-1:0]      shift_word
);
    localparam int unsigned SW = $bits(sense_t);

    sense_t                s;
    logic                  supply_ok;
    logic                  din_s;
    prot_cfg_t             cfg_q;
    prot_cfg_t             cfg_eff;
    out_state_t            st_q;
    logic                  cmd;
    logic                  cmd_q;
    logic                  uv_lock_q;
    logic [WORD_BITS-1:0]  flags_q;
    logic [WORD_BITS-1:0]  set_v;
    logic                  oc_low_lvl;
    logic                  oc_high_lvl;
    logic                  oc_low_exp;
    logic [FILT_CNT_W-1:0] filt_lim;
    logic                  thermal_act;
    logic                  therm_hold_q;
    logic                  hibat_act;
    logic                  lobat_act;
    logic                  open_act;
    logic                  allowed;

    sync2 #(.W(SW + 2)) u_sync (
        .clock (clock),
        .rst   (rst),
        .din   ({sense, logic_supply_ok, direct_in}),
        .dout  ({s, supply_ok, din_s})
    );

    // Configuration: held at defaults while the logic supply is out
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cfg_q <= CFG_DEFAULT;
        else if (!supply_ok)
            cfg_q <= CFG_DEFAULT;
        else if (cfg_load)
            cfg_q <= cfg_in;
    end

    assign cfg_eff = supply_ok ? cfg_q : CFG_DEFAULT;
    assign cmd     = supply_ok ? (serial_on_cmd | din_s) : din_s;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sense_ratio_default <= 1'b1;
        else
            sense_ratio_default <= !supply_ok;
    end

    // Level selection: one low and one high level active at a time
    assign oc_low_lvl  = s.oc_low_hit[cfg_eff.low_overcurrent_level];
    assign oc_high_lvl = s.oc_high_hit[cfg_eff.high_overcurrent_level];

    always_comb
    begin
        case (cfg_eff.overcurrent_filter_time)
            2'h0:    filt_lim = FILT_CNT_W'(OC_FILT_US0 * CYC_PER_US);
            2'h1:    filt_lim = FILT_CNT_W'(OC_FILT_US1 * CYC_PER_US);
            2'h2:    filt_lim = FILT_CNT_W'(OC_FILT_US2 * CYC_PER_US);
            default: filt_lim = FILT_CNT_W'(OC_FILT_US3 * CYC_PER_US);
        endcase
    end

    oc_filter #(.CW(FILT_CNT_W)) u_filt (
        .clock   (clock),
        .rst     (rst),
        .active  (oc_low_lvl && st_q == OUT_ON),
        .limit   (filt_lim),
        .expired (oc_low_exp)
    );

    assign thermal_act = s.over_temp && st_q == OUT_ON;
    assign hibat_act   = s.over_volt && !cfg_eff.high_battery_guard_off;
    assign lobat_act   = s.below_uv && !s.below_por && !cfg_eff.low_battery_guard_off;
    assign open_act    = s.open_load && s.gate_low && st_q != OUT_ON
                         && !cfg_eff.open_detect_off;

    // Non-latching faults block the output only while present
    assign allowed = !thermal_act && !therm_hold_q && !hibat_act && !lobat_act && !s.gnd_lost
                     && s.above_min
                     && !(s.below_por && !cfg_eff.low_battery_guard_off);

    // Thermal shutdown holds until the sensor clears or the command drops, else the output would chatter
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            therm_hold_q <= 1'b0;
        else if (!s.over_temp || !cmd)
            therm_hold_q <= 1'b0;
        else if (thermal_act)
            therm_hold_q <= 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cmd_q <= 1'b0;
        else
            cmd_q <= cmd;
    end

    // Output state: overcurrent and undervoltage-with-command-on latch off
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            st_q <= OUT_IDLE;
        else
        begin
            case (st_q)
                OUT_IDLE:
                    if (cmd && allowed && !uv_lock_q)
                        st_q <= OUT_ON;
                OUT_ON:
                    if (oc_high_lvl || oc_low_exp)
                        st_q <= OUT_LATCHED;
                    else if (!cmd || !allowed)
                        st_q <= OUT_IDLE;
                OUT_LATCHED:
                    if (!cmd)
                        st_q <= OUT_IDLE;
                default:
                    st_q <= OUT_IDLE;
            endcase
        end
    end

    // Undervoltage while commanded on locks output until off-on cycle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            uv_lock_q <= 1'b0;
        else if (!cmd)
            uv_lock_q <= 1'b0;
        else if (lobat_act && cmd_q)
            uv_lock_q <= 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            output_gate <= 1'b0;
        else
            output_gate <= (st_q == OUT_ON) && cmd && allowed
                           && !oc_high_lvl && !oc_low_exp;
    end

    always_comb
    begin
        set_v             = '0;
        set_v[ST_THERMAL] = thermal_act;
        set_v[ST_HIGHBAT] = hibat_act;
        set_v[ST_LOWBAT]  = (s.below_uv || s.below_por) && !cfg_eff.low_battery_guard_off;
        set_v[ST_OPEN]    = open_act;
        set_v[ST_OC_LOW]  = oc_low_exp && st_q == OUT_ON;
        set_v[ST_OC_HIGH] = oc_high_lvl && st_q == OUT_ON;
        set_v[ST_GND]     = s.gnd_lost;
    end

    // Sticky flags: set wins over the read clear
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            flags_q <= STATUS_RST;
        else if (read_valid)
            flags_q <= set_v;
        else
            flags_q <= flags_q | set_v;
    end

    // Snapshot on frame start, before any clear by the read
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            shift_word <= STATUS_RST;
        else if (frame_start)
            shift_word <= {output_gate, flags_q[ST_GND:0] | set_v[ST_GND:0]};
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            status_word <= STATUS_RST;
        else
            status_word <= {output_gate, flags_q[ST_GND:0]};
    end

    // Fault pad: live faults, plus latched overcurrent and undervoltage lock
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            fault_indicator_pad_n <= 1'b1;
        else
            fault_indicator_pad_n <= !(thermal_act || therm_hold_q || hibat_act || lobat_act
                                       || open_act
                                       || st_q == OUT_LATCHED
                                       || (uv_lock_q && cmd));
    end

    AST_LATCH_OFF: assert property (@(posedge clock) disable iff (rst)
        st_q == OUT_LATCHED |=> !output_gate)
        else $error("output on while overcurrent latched");

    AST_PAD_LATCH: assert property (@(posedge clock) disable iff (rst)
        st_q == OUT_LATCHED |=> !fault_indicator_pad_n)
        else $error("fault pad high during overcurrent latch");

    AST_GND_OFF: assert property (@(posedge clock) disable iff (rst)
        s.gnd_lost |=> !output_gate)
        else $error("output on with ground lost");

    AST_HIBAT_OFF: assert property (@(posedge clock) disable iff (rst)
        hibat_act |=> !output_gate && flags_q[ST_HIGHBAT])
        else $error("battery high not handled");

    AST_GUARD_OFF: assert property (@(posedge clock) disable iff (rst)
        cfg_eff.high_battery_guard_off && !flags_q[ST_HIGHBAT] |=> !flags_q[ST_HIGHBAT])
        else $error("battery high reported while disabled");

    AST_THERM_FLAG: assert property (@(posedge clock) disable iff (rst)
        thermal_act && !read_valid |=> flags_q[ST_THERMAL] [*1])
        else $error("thermal flag not set");

    AST_THERM_HOLD: assert property (@(posedge clock) disable iff (rst)
        therm_hold_q |=> !output_gate)
        else $error("output on during thermal hold");

    AST_CFG_DEF: assert property (@(posedge clock) disable iff (rst)
        !supply_ok |=> cfg_q == CFG_DEFAULT)
        else $error("config kept without logic supply");

    AST_SNAP: assert property (@(posedge clock) disable iff (rst)
        frame_start && flags_q[ST_OPEN] |=> shift_word[ST_OPEN])
        else $error("flag lost from shift word");

    AST_OPEN_OFF: assert property (@(posedge clock) disable iff (rst)
        open_act |=> flags_q[ST_OPEN] && !output_gate)
        else $error("open load not latched while off");

    AST_HIGH_OC: assert property (@(posedge clock) disable iff (rst)
        oc_high_lvl && st_q == OUT_ON |=> st_q == OUT_LATCHED ##1 !output_gate)
        else $error("high overcurrent not latched at once");

    AST_UV_LOCK: assert property (@(posedge clock) disable iff (rst)
        uv_lock_q && cmd |=> !output_gate && !fault_indicator_pad_n)
        else $error("undervoltage lock released early");

    AST_POR_OFF: assert property (@(posedge clock) disable iff (rst)
        s.below_por && !cfg_eff.low_battery_guard_off |=> !output_gate)
        else $error("output on below reset threshold");

    AST_BELOW_MIN: assert property (@(posedge clock) disable iff (rst)
        !s.above_min |=> !output_gate)
        else $error("output on below minimum battery");

endmodule : high_side_fault_supervisor
`default_nettype wire

// [sim/host_model.sv]
// Host model: serial on command, protection configuration and status reads.
// Assumes the supervisor samples these levels and pulses on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module host_model
    import fault_sup_pkg::*;
(
    input  wire logic      clock,
    output var  logic      frame_start,
    output var  logic      read_valid,
    output var  logic      serial_on_cmd,
    output var  prot_cfg_t cfg_in,
    output var  logic      cfg_load
);
    initial
    begin
        frame_start   = 1'b0;
        read_valid    = 1'b0;
        serial_on_cmd = 1'b0;
        cfg_in        = CFG_DEFAULT;
        cfg_load      = 1'b0;
    end

    task automatic command(input logic on);
        @(negedge clock);
        serial_on_cmd = on;
    endtask : command

    task automatic configure(input prot_cfg_t c);
        @(negedge clock);
        cfg_in   = c;
        cfg_load = 1'b1;
        @(negedge clock);
        cfg_load = 1'b0;
    endtask : configure

    // Chip-select fall snapshots the flags, a whole byte later the transfer counts as valid
    task automatic read_word();
        @(negedge clock);
        frame_start = 1'b1;
        @(negedge clock);
        frame_start = 1'b0;
        repeat (WORD_BITS) @(negedge clock);
        read_valid = 1'b1;
        @(negedge clock);
        read_valid = 1'b0;
    endtask : read_word
endmodule : host_model
`default_nettype wire

// [sim/high_side_fault_supervisor_test.sv]
// Self-checking bench for the fault supervisor with a host model on the serial side.
// Assumes the package constants; sense levels are driven directly as comparator outputs.
`timescale 1ns/10ps
`default_nettype none
module high_side_fault_supervisor_test
    import fault_sup_pkg::*;
;
    logic clock, rst, logic_supply_ok, direct_in, frame_start, read_valid, serial_on_cmd, cfg_load;
    logic output_gate, fault_indicator_pad_n, sense_ratio_default;
    logic [WORD_BITS-1:0] status_word, shift_word;
    prot_cfg_t cfg_in, cfg;
    sense_t    sense;
    int        n_fail, compares, seed, lvl, fsel, hs, i;

    high_side_fault_supervisor dut_u (
        .clock(clock), .rst(rst), .logic_supply_ok(logic_supply_ok), .direct_in(direct_in),
        .serial_on_cmd(serial_on_cmd), .cfg_in(cfg_in), .cfg_load(cfg_load),
        .frame_start(frame_start), .read_valid(read_valid), .sense(sense),
        .output_gate(output_gate), .fault_indicator_pad_n(fault_indicator_pad_n),
        .sense_ratio_default(sense_ratio_default), .status_word(status_word),
        .shift_word(shift_word));

    host_model host_u (
        .clock(clock), .frame_start(frame_start), .read_valid(read_valid),
        .serial_on_cmd(serial_on_cmd), .cfg_in(cfg_in), .cfg_load(cfg_load));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] flag(input int unsigned pos);
        return 8'h01 << pos;
    endfunction : flag

    function automatic int filt_cycles(input int sel);
        int unsigned us[4] = '{OC_FILT_US0, OC_FILT_US1, OC_FILT_US2, OC_FILT_US3};
        return us[sel] * CYC_PER_US;
    endfunction : filt_cycles

    // Status bit at pos must equal on
    task automatic flag_is(input int unsigned pos, input logic on);
        check(status_word & flag(pos), on ? flag(pos) : 8'h00);
    endtask : flag_is

    task automatic settle();
        repeat (8) @(negedge clock);
    endtask : settle

    task automatic toggle_on();
        host_u.command(1'b0);
        settle();
        host_u.command(1'b1);
        settle();
    endtask : toggle_on

    task automatic read_clear();
        host_u.read_word();
        settle();
    endtask : read_clear

    task automatic results();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial
    begin
        #(25 * 40000);
        n_fail++;
        results();
    end

    initial
    begin
        n_fail = 0;
        compares = 0;
        seed = 32'h7085;
        rst = 1'b1;
        logic_supply_ok = 1'b1;
        direct_in = 1'b0;
        sense = '0;
        sense.above_min = 1'b1;
        repeat (6) @(negedge clock);
        rst = 1'b0;
        settle();
        check(status_word, STATUS_RST);
        check(fault_indicator_pad_n, 8'h01);
        check(sense_ratio_default, 8'h00);
        // Thermal cycling while on, then off
        host_u.command(1'b1);
        settle();
        flag_is(ST_OUTON, 1'b1);
        for (i = 0; i < 2; i++)
        begin
            sense.over_temp = 1'b1;
            settle();
            check(output_gate, 8'h00);
            check(fault_indicator_pad_n, 8'h00);
            sense.over_temp = 1'b0;
            settle();
            check(output_gate, 8'h01);
            check(fault_indicator_pad_n, 8'h01);
            flag_is(ST_THERMAL, 1'b1);
        end
        host_u.read_word();
        check(shift_word & flag(ST_THERMAL), flag(ST_THERMAL));
        settle();
        flag_is(ST_THERMAL, 1'b0);
        host_u.read_word();
        check(shift_word & flag(ST_THERMAL), 8'h00);
        host_u.command(1'b0);
        sense.over_temp = 1'b1;
        settle();
        flag_is(ST_THERMAL, 1'b0);
        check(fault_indicator_pad_n, 8'h01);
        sense.over_temp = 1'b0;
        // Battery high with guard on and off
        for (i = 0; i < 2; i++)
        begin
            cfg = CFG_DEFAULT;
            cfg.high_battery_guard_off = i[0];
            host_u.configure(cfg);
            host_u.command(1'b1);
            settle();
            sense.over_volt = 1'b1;
            settle();
            check(output_gate, {7'h00, i[0]});
            flag_is(ST_HIGHBAT, !i[0]);
            check(fault_indicator_pad_n, {7'h00, i[0]});
            sense.over_volt = 1'b0;
            settle();
            check(output_gate, 8'h01);
            read_clear();
        end
        host_u.configure(CFG_DEFAULT);
        // Battery low, recovering with the command on
        sense.below_uv = 1'b1;
        settle();
        check(output_gate, 8'h00);
        check(fault_indicator_pad_n, 8'h00);
        flag_is(ST_LOWBAT, 1'b1);
        sense.below_uv = 1'b0;
        settle();
        check(output_gate, 8'h00);
        check(fault_indicator_pad_n, 8'h00);
        toggle_on();
        check(output_gate, 8'h01);
        check(fault_indicator_pad_n, 8'h01);
        flag_is(ST_LOWBAT, 1'b1);
        read_clear();
        flag_is(ST_LOWBAT, 1'b0);
        // Recovering with the command off
        host_u.command(1'b0);
        sense.below_uv = 1'b1;
        settle();
        sense.below_uv = 1'b0;
        settle();
        check(fault_indicator_pad_n, 8'h01);
        flag_is(ST_LOWBAT, 1'b1);
        read_clear();
        // Between the reset threshold and the minimum
        host_u.command(1'b1);
        sense.below_uv = 1'b1;
        sense.below_por = 1'b1;
        settle();
        check(output_gate, 8'h00);
        check(fault_indicator_pad_n, 8'h01);
        flag_is(ST_LOWBAT, 1'b1);
        sense.below_por = 1'b0;
        sense.below_uv = 1'b0;
        toggle_on();
        read_clear();
        cfg = CFG_DEFAULT;
        cfg.low_battery_guard_off = 1'b1;
        host_u.configure(cfg);
        sense.below_uv = 1'b1;
        settle();
        check(output_gate, 8'h01);
        check(fault_indicator_pad_n, 8'h01);
        flag_is(ST_LOWBAT, 1'b0);
        sense.above_min = 1'b0;
        settle();
        check(output_gate, 8'h00);
        check(fault_indicator_pad_n, 8'h01);
        sense.above_min = 1'b1;
        settle();
        check(output_gate, 8'h01);
        sense.below_uv = 1'b0;
        // Open load, only while off
        sense.open_load = 1'b1;
        settle();
        flag_is(ST_OPEN, 1'b0);
        host_u.command(1'b0);
        sense.gate_low = 1'b1;
        settle();
        flag_is(ST_OPEN, 1'b1);
        check(fault_indicator_pad_n, 8'h00);
        sense.open_load = 1'b0;
        settle();
        check(fault_indicator_pad_n, 8'h01);
        read_clear();
        flag_is(ST_OPEN, 1'b0);
        cfg.open_detect_off = 1'b1;
        host_u.configure(cfg);
        sense.open_load = 1'b1;
        settle();
        flag_is(ST_OPEN, 1'b0);
        sense.open_load = 1'b0;
        sense.gate_low = 1'b0;
        // Random overcurrent levels and filter times
        for (i = 0; i < 4; i++)
        begin
            lvl = $unsigned($random(seed)) % 8;
            fsel = (i == 0) ? 3 : $unsigned($random(seed)) % 4;
            hs = $unsigned($random(seed)) % 2;
            cfg = CFG_DEFAULT;
            cfg.low_overcurrent_level = lvl[2:0];
            cfg.overcurrent_filter_time = fsel[1:0];
            cfg.high_overcurrent_level = hs[0];
            host_u.configure(cfg);
            toggle_on();
            sense.oc_low_hit = ~(8'h01 << lvl);
            sense.oc_high_hit = 2'b01 << (1 - hs);
            repeat (filt_cycles(fsel) + 20) @(negedge clock);
            check(output_gate, 8'h01);
            sense.oc_low_hit = 8'hff;
            repeat (filt_cycles(fsel) - 4) @(negedge clock);
            check(output_gate, 8'h01);
            repeat (20) @(negedge clock);
            check(output_gate, 8'h00);
            flag_is(ST_OC_LOW, 1'b1);
            sense.oc_low_hit = '0;
            sense.oc_high_hit = '0;
            settle();
            check(output_gate, 8'h00);
            check(fault_indicator_pad_n, 8'h00);
            toggle_on();
            check(output_gate, 8'h01);
            read_clear();
            sense.oc_high_hit = 2'b01 << hs;
            settle();
            check(output_gate, 8'h00);
            flag_is(ST_OC_HIGH, 1'b1);
            sense.oc_high_hit = '0;
            toggle_on();
            check(output_gate, 8'h01);
            read_clear();
        end
        sense.gnd_lost = 1'b1;
        settle();
        check(output_gate, 8'h00);
        flag_is(ST_GND, 1'b1);
        sense.gnd_lost = 1'b0;
        host_u.command(1'b0);
        read_clear();
        // Logic supply lost: defaults, direct input only
        cfg = CFG_DEFAULT;
        cfg.high_battery_guard_off = 1'b1;
        host_u.configure(cfg);
        logic_supply_ok = 1'b0;
        host_u.command(1'b1);
        settle();
        check(sense_ratio_default, 8'h01);
        check(output_gate, 8'h00);
        direct_in = 1'b1;
        settle();
        check(output_gate, 8'h01);
        sense.over_volt = 1'b1;
        settle();
        check(output_gate, 8'h00);
        sense.over_volt = 1'b0;
        // Random supply, direct input and serial command mixes
        for (i = 0; i < 8; i++)
        begin
            lvl = $random(seed);
            direct_in = lvl[0];
            logic_supply_ok = lvl[1];
            host_u.command(lvl[2]);
            settle();
            check(output_gate, {7'h00, lvl[0] | (lvl[1] & lvl[2])});
            check(sense_ratio_default, {7'h00, !lvl[1]});
        end
        direct_in = 1'b0;
        logic_supply_ok = 1'b1;
        settle();
        check(sense_ratio_default, 8'h00);
        results();
    end
endmodule : high_side_fault_supervisor_test
`default_nettype wire
